/* File: rtl/error_queue_defines.vh */
// constants for the remote-command error queue
`ifndef ERROR_QUEUE_DEFINES_VH
`define ERROR_QUEUE_DEFINES_VH

// entry width and queue depth
`define EQ_CODE_W 11
`define EQ_DEPTH 20
`define EQ_PTR_W 5

// signed error codes, two's complement in EQ_CODE_W bits
`define EQ_NO_ERROR 11'h000
`define EQ_INVALID_CHAR 11'h79b
`define EQ_SYNTAX 11'h79a
`define EQ_SEPARATOR 11'h799
`define EQ_PARAM_EXTRA 11'h794
`define EQ_PARAM_MISSING 11'h793
`define EQ_NUM_OVERFLOW 11'h785
`define EQ_TOO_MANY_DIGITS 11'h784
`define EQ_TRIG_IGNORED 11'h72d
`define EQ_TRIG_DEADLOCK 11'h72b
`define EQ_INIT_IGNORED 11'h72a
`define EQ_DATA_STALE 11'h71a
`define EQ_QUEUE_OVERFLOW 11'h6a2
`define EQ_QUERY_INTERRUPTED 11'h666
`define EQ_QUERY_UNTERMINATED 11'h65c
`define EQ_QUERY_DEADLOCKED 11'h652
`define EQ_NO_MEMORY 11'h213
`define EQ_OVERLOAD_REF 11'h21c
`define EQ_NOT_IN_LOCAL 11'h226

// limits checked by the error detectors
`define EQ_EXP_LIMIT 16'h7d00
`define EQ_DIGIT_LIMIT 9'h0ff
`define EQ_MAX_READINGS 32'h0000_0200

`endif

/* File: rtl/error_queue.v */
// error detectors and first-in-first-out error queue of the command handler
`include "error_queue_defines.vh"

module error_queue #(
    parameter DEPTH = `EQ_DEPTH,
    parameter PW = `EQ_PTR_W,
    parameter CNT_W = 16
) (
    // clock and power-on reset
    input wire clk_sys,
    input wire rst_b,
    // parser events
    input wire bad_char_evt,
    input wire bad_syntax_evt,
    input wire bad_sep_evt,
    input wire cmd_end_evt,
    input wire [3:0] param_given,
    input wire [3:0] param_needed,
    input wire num_end_evt,
    input wire [15:0] num_exponent,
    input wire [8:0] num_digits,
    // trigger and measurement events
    input wire bus_trig_evt,
    input wire wait_trig,
    input wire read_query_evt,
    input wire trig_src_bus,
    input wire local_mode,
    input wire init_evt,
    input wire meas_busy,
    input wire fetch_evt,
    input wire mem_empty,
    // output buffer events
    input wire resp_cmd_evt,
    input wire outbuf_has_data,
    input wire talk_evt,
    input wire resp_ovf_evt,
    input wire inbuf_full,
    // count and math events
    input wire count_set_evt,
    input wire [CNT_W-1:0] sample_count,
    input wire [CNT_W-1:0] trig_count,
    input wire math_ref_evt,
    input wire ref_overload,
    // other errors from elsewhere in the handler
    input wire ext_err_evt,
    input wire [`EQ_CODE_W-1:0] ext_err_code,
    // host access to the queue
    input wire err_read_req,
    input wire clear_status_evt,
    output reg [`EQ_CODE_W-1:0] err_code_out,
    output reg err_read_valid,
    output reg [PW-1:0] err_count,
    // indicators and side effects
    output reg err_led,
    output reg beep,
    output reg trig_accept,
    output reg init_go,
    output reg resp_discard,
    output reg math_off,
    output reg ref_store
);

    localparam [PW-1:0] DEPTH_P = DEPTH;
    localparam [PW-1:0] LAST_P = DEPTH - 1;
    localparam [PW-1:0] ONE_P = 1;
    localparam [2*CNT_W-1:0] MAX_RD = `EQ_MAX_READINGS;

    // queue storage and pointers
    reg [`EQ_CODE_W-1:0] mem_reg [0:DEPTH-1];
    reg [PW-1:0] rd_reg;
    reg [PW-1:0] wr_reg;
    reg ovf_reg;

    // detector results
    reg log_req;
    reg [`EQ_CODE_W-1:0] log_code;
    wire [2*CNT_W-1:0] readings;

    // queue next-state terms
    reg pop;
    reg [PW-1:0] cnt_next;
    reg [PW-1:0] rd_next;
    reg [PW-1:0] wr_base;
    reg [PW-1:0] wr_next;
    reg ovf_next;
    reg accept;
    reg replace;
    reg [PW-1:0] newest;

    assign readings = sample_count * trig_count;

    // pick one error per cycle, parser faults first
    always @* begin
        log_req = 1'b1;
        log_code = `EQ_NO_ERROR;
        if (bad_char_evt) begin
            log_code = `EQ_INVALID_CHAR;
        end else if (bad_syntax_evt) begin
            log_code = `EQ_SYNTAX;
        end else if (bad_sep_evt) begin
            log_code = `EQ_SEPARATOR;
        end else if (cmd_end_evt && param_given > param_needed) begin
            log_code = `EQ_PARAM_EXTRA;
        end else if (cmd_end_evt && param_given < param_needed) begin
            log_code = `EQ_PARAM_MISSING;
        end else if (num_end_evt && num_exponent > `EQ_EXP_LIMIT) begin
            log_code = `EQ_NUM_OVERFLOW;
        end else if (num_end_evt && num_digits > `EQ_DIGIT_LIMIT) begin
            log_code = `EQ_TOO_MANY_DIGITS;
        end else if (bus_trig_evt && !wait_trig) begin
            log_code = `EQ_TRIG_IGNORED;
        end else if (read_query_evt && local_mode) begin
            log_code = `EQ_NOT_IN_LOCAL;
        end else if (read_query_evt && trig_src_bus) begin
            log_code = `EQ_TRIG_DEADLOCK;
        end else if (init_evt && meas_busy) begin
            log_code = `EQ_INIT_IGNORED;
        end else if (fetch_evt && mem_empty) begin
            log_code = `EQ_DATA_STALE;
        end else if (resp_cmd_evt && outbuf_has_data) begin
            log_code = `EQ_QUERY_INTERRUPTED;
        end else if (talk_evt && !outbuf_has_data) begin
            log_code = `EQ_QUERY_UNTERMINATED;
        end else if (resp_ovf_evt && inbuf_full) begin
            log_code = `EQ_QUERY_DEADLOCKED;
        end else if (count_set_evt && readings > MAX_RD) begin
            log_code = `EQ_NO_MEMORY;
        end else if (math_ref_evt && ref_overload) begin
            log_code = `EQ_OVERLOAD_REF;
        end else if (ext_err_evt) begin
            log_code = ext_err_code;
        end else begin
            log_req = 1'b0;
        end
    end

    // read and clear act first, then the new error lands
    always @* begin
        pop = err_read_req && (err_count != {PW{1'b0}});
        if (clear_status_evt) begin
            cnt_next = {PW{1'b0}};
            rd_next = {PW{1'b0}};
            wr_base = {PW{1'b0}};
            ovf_next = 1'b0;
        end else begin
            cnt_next = pop ? err_count - ONE_P : err_count;
            rd_next = rd_reg;
            if (pop) begin
                rd_next = (rd_reg == LAST_P) ? {PW{1'b0}} : rd_reg + ONE_P;
            end
            wr_base = wr_reg;
            ovf_next = pop ? 1'b0 : ovf_reg;
        end
        newest = (wr_base == {PW{1'b0}}) ? LAST_P : wr_base - ONE_P;
        accept = log_req && !ovf_next && (cnt_next != DEPTH_P);
        replace = log_req && !ovf_next && (cnt_next == DEPTH_P);
        wr_next = wr_base;
        if (accept) begin
            wr_next = (wr_base == LAST_P) ? {PW{1'b0}} : wr_base + ONE_P;
            cnt_next = cnt_next + ONE_P;
        end
        if (replace) begin
            ovf_next = 1'b1;
        end
    end

    // entry storage, written in arrival order
    always @(posedge clk_sys) begin
        if (accept) begin
            mem_reg[wr_base] <= log_code;
        end else if (replace) begin
            mem_reg[newest] <= `EQ_QUEUE_OVERFLOW;
        end
    end

    // pointers, count and overflow marker
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_reg <= {PW{1'b0}};
            wr_reg <= {PW{1'b0}};
            err_count <= {PW{1'b0}};
            ovf_reg <= 1'b0;
        end else begin
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            err_count <= cnt_next;
            ovf_reg <= ovf_next;
        end
    end

    // host read port and indicators
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            err_code_out <= `EQ_NO_ERROR;
            err_read_valid <= 1'b0;
            err_led <= 1'b0;
            beep <= 1'b0;
        end else begin
            err_read_valid <= err_read_req;
            if (err_read_req) begin
                if (err_count != {PW{1'b0}}) begin
                    err_code_out <= mem_reg[rd_reg];
                end else begin
                    err_code_out <= `EQ_NO_ERROR;
                end
            end
            err_led <= (cnt_next != {PW{1'b0}});
            beep <= accept || replace;
        end
    end

    // side effects of the checked commands
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            trig_accept <= 1'b0;
            init_go <= 1'b0;
            resp_discard <= 1'b0;
            math_off <= 1'b0;
            ref_store <= 1'b0;
        end else begin
            trig_accept <= bus_trig_evt && wait_trig;
            init_go <= init_evt && !meas_busy;
            resp_discard <= resp_ovf_evt && inbuf_full;
            math_off <= math_ref_evt && ref_overload;
            ref_store <= math_ref_evt && !ref_overload;
        end
    end

endmodule

/* File: testbench/error_queue_chk.sv */
// concurrent checks on the error queue ports
module error_queue_chk (
    // clock, reset and stimulus seen
    input wire logic clk_sys, rst_b, bad_char_evt, ext_err_evt, err_read_req,
    input wire logic clear_status_evt, bus_trig_evt, wait_trig, init_evt, meas_busy,
    input wire logic math_ref_evt, ref_overload, resp_ovf_evt, inbuf_full,
    // outputs watched
    input wire logic [10:0] err_code_out,
    input wire logic [4:0] err_count,
    input wire logic err_read_valid, err_led, beep, trig_accept, init_go,
    input wire logic math_off, ref_store, resp_discard
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // neither bad_char_evt nor ext_err_evt active this cycle
    sequence s_quiet;
        !bad_char_evt && !ext_err_evt;
    endsequence
    // queue has room and no overflow marker
    sequence s_room;
        err_count < 5'd20;
    endsequence
    property p_pop; err_read_req && err_count != 5'd0 ##0 s_quiet
        |=> err_read_valid && err_count == $past(err_count) - 5'd1; endproperty
    a_pop: assert property (p_pop) else $error("pop did not drop count");
    property p_cap; err_count <= 5'd20; endproperty
    a_cap: assert property (p_cap) else $error("count above depth");
    property p_empty; err_read_req && err_count == 5'd0 ##0 s_quiet
        |=> err_read_valid && err_code_out == 11'h000; endproperty
    a_empty: assert property (p_empty) else $error("empty read not zero");
    property p_led; err_led == (err_count != 5'd0); endproperty
    a_led: assert property (p_led) else $error("indicator wrong");
    property p_beep; bad_char_evt ##0 s_room |=> beep ##1 !beep; endproperty
    a_beep: assert property (p_beep) else $error("no single beep");
    property p_cls; clear_status_evt ##0 s_quiet |=> err_count == 5'd0; endproperty
    a_cls: assert property (p_cls) else $error("clear left entries");
    property p_trig; bus_trig_evt && !wait_trig |=> !trig_accept; endproperty
    a_trig: assert property (p_trig) else $error("stray trigger taken");
    property p_init; init_evt && meas_busy |=> !init_go; endproperty
    a_init: assert property (p_init) else $error("initiate while busy");
    property p_disc; resp_ovf_evt && inbuf_full |=> resp_discard; endproperty
    a_disc: assert property (p_disc) else $error("response not discarded");
    property p_math; math_ref_evt && ref_overload |=> math_off && !ref_store; endproperty
    a_math: assert property (p_math) else $error("overload stored");
endmodule

/* File: testbench/host_model.sv */
// remote host that pops one entry at a time
module host_model (
    input wire logic clk_sys,
    input wire logic err_read_valid,
    input wire logic [10:0] err_code_out,
    output logic err_read_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial err_read_req = 1'b0;
    // request held for one taken edge, answer sampled after it settles
    task automatic read_one(output logic [10:0] code, output logic ok);
        @(posedge clk_sys);
        err_read_req <= 1'b1;
        @(posedge clk_sys);
        err_read_req <= 1'b0;
        #1;
        ok = err_read_valid;
        code = err_code_out;
    endtask
endmodule

/* File: testbench/test_error_queue.sv */
// self-checking bench for the error queue
module test_error_queue;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, rst_b = 1'b0, ob = 1'b0, clr = 1'b0;
    logic [14:0] ev = '0;
    logic [10:0] xc = '0;
    // condition levels seen by the detectors
    logic [3:0] pg = 4'h3, pn = 4'h2;
    logic [15:0] nexp = 16'h7d01, sc = 16'h0011, tc = 16'h0020;
    logic [8:0] ndig = 9'h000;
    logic wt = 1'b0, tsb = 1'b1, lm = 1'b0, mb = 1'b1, me = 1'b1, ibf = 1'b1, rov = 1'b1;
    wire logic tacc, igo, rstore;
    wire logic rq, vld, led, beep;
    wire logic [10:0] code;
    wire logic [4:0] cnt;
    int num_errors = 0, n_tests = 0, cyc = 0;
    // expected code per event bit
    logic [10:0] tab [15] = '{-11'd101, -11'd102, -11'd103, -11'd108, -11'd123, -11'd211,
        -11'd213, -11'd214, -11'd230, -11'd410, -11'd420, -11'd430, 11'd531, 11'd540, 11'h123};
    always #2 clk_sys = ~clk_sys;
    error_queue error_queue_inst (.clk_sys(clk_sys), .rst_b(rst_b), .bad_char_evt(ev[0]),
        .bad_syntax_evt(ev[1]), .bad_sep_evt(ev[2]), .cmd_end_evt(ev[3]),
        .param_given(pg), .param_needed(pn), .num_end_evt(ev[4]),
        .num_exponent(nexp), .num_digits(ndig), .bus_trig_evt(ev[5]),
        .wait_trig(wt), .read_query_evt(ev[6]), .trig_src_bus(tsb), .local_mode(lm),
        .init_evt(ev[7]), .meas_busy(mb), .fetch_evt(ev[8]), .mem_empty(me),
        .resp_cmd_evt(ev[9]), .outbuf_has_data(ob), .talk_evt(ev[10]),
        .resp_ovf_evt(ev[11]), .inbuf_full(ibf), .count_set_evt(ev[12]),
        .sample_count(sc), .trig_count(tc), .math_ref_evt(ev[13]),
        .ref_overload(rov), .ext_err_evt(ev[14]), .ext_err_code(xc), .err_read_req(rq),
        .clear_status_evt(clr), .err_code_out(code), .err_read_valid(vld),
        .err_count(cnt), .err_led(led), .beep(beep), .trig_accept(tacc), .init_go(igo),
        .resp_discard(), .math_off(), .ref_store(rstore));
    host_model host_model_inst (.clk_sys(clk_sys), .err_read_valid(vld),
        .err_code_out(code), .err_read_req(rq));
    task check(input logic [10:0] s, input logic [10:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task tally_and_finish;
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one event pulse, one cycle wide
    task log_err(input int i, input logic [10:0] c);
        @(posedge clk_sys);
        ev[i] <= 1'b1;
        xc <= c;
        ob <= (i == 9);
        @(posedge clk_sys);
        ev <= '0;
    endtask
    task rd(input logic [10:0] e);
        logic [10:0] c;
        logic v;
        host_model_inst.read_one(c, v);
        check({10'h000, v}, 11'h001);
        check(c, e);
    endtask
    // every error source logs its own code
    task t_codes;
        for (int i = 0; i < 15; i++) begin
            log_err(i, 11'h123);
            rd(tab[i]);
        end
    endtask
    // fill past depth, drop while marked, resume after one read
    task t_fifo;
        for (int i = 1; i <= 22; i++) log_err(14, i[10:0]);
        #1 check({6'h00, cnt}, 11'h014);
        rd(11'h001);
        log_err(14, 11'h063);
        #1 check({6'h00, cnt}, 11'h014);
        for (int i = 2; i < 20; i++) rd(i[10:0]);
        rd(-11'd350);
        rd(11'h063);
        check({10'h000, led}, 11'h000);
        rd(11'h000);
    endtask
    // clear-status empties a partly filled queue
    task t_clear;
        for (int i = 0; i < 3; i++) log_err(14, 11'h007);
        #1 check({10'h000, led}, 11'h001);
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        #1 check({6'h00, cnt}, 11'h000);
        rd(11'h000);
    endtask
    // accepted commands log nothing; other branches of the detectors
    task t_sides;
        @(posedge clk_sys);
        wt <= 1'b1;
        mb <= 1'b0;
        rov <= 1'b0;
        lm <= 1'b1;
        pg <= 4'h1;
        nexp <= 16'h7d00;
        ndig <= 9'h100;
        log_err(5, 11'h000);
        #1 check({10'h000, tacc}, 11'h001);
        log_err(7, 11'h000);
        #1 check({10'h000, igo}, 11'h001);
        log_err(13, 11'h000);
        #1 check({10'h000, rstore}, 11'h001);
        check({6'h00, cnt}, 11'h000);
        log_err(6, 11'h000);
        rd(11'h226);
        log_err(3, 11'h000);
        rd(-11'd109);
        log_err(4, 11'h000);
        rd(-11'd124);
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_codes();
        t_fifo();
        t_clear();
        t_sides();
        tally_and_finish();
    end
endmodule
bind error_queue error_queue_chk error_queue_chk_inst (.*);
